// *** rtl/fal_pkg.sv ***
package fal_pkg;
   // ------------------------------------------------------------
   // timing
   // ------------------------------------------------------------
   localparam int CLK_PERIOD_NS    = 100;          // interface clock period
   localparam int RW_LOW_TIME_NS   = 1000;         // least ready_wait low after reset
   localparam int RW_LOW_CYC       = (RW_LOW_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam int CAPTURE_EDGE     = 3;            // edge that latches the address
   localparam int SEQ_EDGES        = 4;            // length of the capture sequence
   localparam real PARAM_ERASE_S   = 2.5;          // parameter block erase, longest
   localparam real MAIN_ERASE_S    = 4.0;          // main block erase, longest
   localparam longint PARAM_ERASE_CYC = longint'(PARAM_ERASE_S * 1.0e9 / CLK_PERIOD_NS);
   localparam longint MAIN_ERASE_CYC  = longint'(MAIN_ERASE_S * 1.0e9 / CLK_PERIOD_NS);
   // ------------------------------------------------------------
   // widths and reset values
   // ------------------------------------------------------------
   localparam int ADDR_W           = 23;           // word address of main array
   localparam int DATA_W           = 16;           // data bus width
   localparam logic [22:0] ADDR_RST = 23'h000000;  // start address after reset
   localparam logic [1:0]  SEQ_CNT_RST = 2'h0;     // sequence edge count reset

   // sequence states
   typedef enum logic [1:0] {
      FAL_HOLD  = 2'b00,  // ready_wait held low
      FAL_WAIT  = 2'b01,  // released, waiting for start condition
      FAL_SEQ   = 2'b10,  // counting clock edges
      FAL_BURST = 2'b11   // delivering burst data
   } fal_state_t;

   // reader-side controls sampled together
   typedef struct packed {
      logic oe_n;          // output enable, active low
      logic addr_valid;    // address valid strobe
      logic hard_reset_n;  // reset pin
   } fal_ctl_t;

   // data toward the reader
   typedef struct packed {
      logic [15:0] data;   // read word
      logic        oe;     // data bus enable
   } fal_dout_t;
endpackage

// *** rtl/fal_erase_timer.sv ***
`timescale 1ns/100ps
// ------------------------------------------------------------
// erase duration bound: busy while an erase runs, ends by limit
// ------------------------------------------------------------
module fal_erase_timer #(
   parameter longint PARAM_CYC = fal_pkg::PARAM_ERASE_CYC,
   parameter longint MAIN_CYC  = fal_pkg::MAIN_ERASE_CYC
) (
   input  wire logic ref_clk_i,
   input  wire logic reset_i,
   input  wire logic start_i,       // one-cycle erase request
   input  wire logic is_main_i,     // main block (else parameter)
   output logic      busy_o         // erase in progress
);
   import fal_pkg::*;
   logic [31:0] cnt_ff;             // cycles left
   logic [31:0] nxt_cnt;
   logic        busy_ff;
   // load limit on start, count down otherwise
   assign nxt_cnt = start_i ? (is_main_i ? 32'(MAIN_CYC) : 32'(PARAM_CYC))
                            : (cnt_ff != 32'h0 ? cnt_ff - 32'h1 : 32'h0);
   always_ff @(posedge ref_clk_i or posedge reset_i) begin
      if (reset_i) begin
         cnt_ff  <= 32'h0;
         busy_ff <= 1'b0;
      end else begin
         cnt_ff  <= nxt_cnt;
         busy_ff <= (nxt_cnt != 32'h0);
      end
   end
   assign busy_o = busy_ff;
endmodule

// *** rtl/fal_first_addr.sv ***
`timescale 1ns/100ps
// Function
// - capture handshake lasts four clock cycles
// - latch address on third edge of the sequence
// - ready_wait low with bit4 resets sequence
// - after power-on: later of two events starts
// - otherwise only ready_wait rise starts sequence
// - burst starts from any latched address
// - erase bounded: 2.5 s parameter, 4 s main
// - ready_wait low during reset, then minimum delay
module fal_first_addr #(
   parameter int RW_LOW = fal_pkg::RW_LOW_CYC,
   parameter int AW     = fal_pkg::ADDR_W,
   parameter int DW     = fal_pkg::DATA_W
) (
   input  wire logic                ref_clk_i,
   input  wire logic                reset_i,       // power-on reset
   input  wire fal_pkg::fal_ctl_t   ctl_i,         // reader controls
   input  wire logic [AW-1:0]       addr_i,        // reader address
   input  wire logic                cfg_bit4_i,    // config_reg_bit4
   input  wire logic [DW-1:0]       array_data_i,  // array word at array_addr_o
   input  wire logic                erase_start_i, // erase request
   input  wire logic                erase_main_i,  // erase target is main block
   output logic                     ready_wait_o,  // config_ready_wait level
   output logic                     ready_wait_oe_o, // high while pin driven low
   output logic [AW-1:0]            array_addr_o,  // burst address
   output fal_pkg::fal_dout_t       dout_o,        // data toward reader
   output logic                     erase_busy_o   // erase in progress
);
   import fal_pkg::*;

   // ------------------------------------------------------------
   // state
   // ------------------------------------------------------------
   fal_state_t        state_ff, nxt_state;   // sequence state
   logic [15:0]       low_cnt_ff;            // ready_wait hold counter
   logic [1:0]        seq_cnt_ff;            // edges seen in sequence
   logic              por_ff;                // still in power-on phase
   logic              oe_seen_ff;            // oe fell while the pin was high
   logic              oe_n_d_ff;             // oe history for edge detect
   logic [AW-1:0]     addr_ff;               // latched / running address
   logic              rw_ff;                 // ready_wait pin level
   logic              rw_d_ff;               // rw history for edge detect
   fal_dout_t         dout_ff;               // output register
   logic              busy_w;                // erase busy from timer

   // ------------------------------------------------------------
   // decode
   // ------------------------------------------------------------
   wire hold_w    = ~ctl_i.hard_reset_n;                 // pin reset holds low
   wire rw_rise_w = rw_ff & ~rw_d_ff;                    // release event
   wire oe_fall_w = oe_n_d_ff & ~ctl_i.oe_n;             // output enable fell
   wire cond_w    = ctl_i.addr_valid & ctl_i.hard_reset_n & ~ctl_i.oe_n;
   // power-on: start on whichever came last, the rw rise or the oe fall;
   // an oe already low at release leaves the rw rise as the later event
   wire por_go_w  = por_ff & rw_ff & (rw_rise_w | oe_seen_ff | oe_fall_w) & cond_w;
   // later on only the ready_wait rise counts
   wire run_go_w  = ~por_ff & rw_rise_w & cond_w;
   wire start_w   = (state_ff == FAL_WAIT) & (por_go_w | run_go_w);
   wire cap_w     = (state_ff == FAL_SEQ) & (seq_cnt_ff == 2'(CAPTURE_EDGE - 1));
   wire seq_end_w = (state_ff == FAL_SEQ) & (seq_cnt_ff == 2'(SEQ_EDGES - 1));
   wire rel_w     = (low_cnt_ff == 16'(RW_LOW));         // hold time elapsed

   // ------------------------------------------------------------
   // next state
   // ------------------------------------------------------------
   // hold releases into wait, wait into sequence on a start,
   // sequence into burst after the fourth edge; burst runs until a reset
   always_comb begin
      nxt_state = state_ff;
      case (state_ff)
         FAL_HOLD: begin
            if (rel_w) begin
               nxt_state = FAL_WAIT;
            end
         end
         FAL_WAIT: begin
            if (start_w) begin
               nxt_state = FAL_SEQ;
            end
         end
         FAL_SEQ: begin
            if (seq_end_w) begin
               nxt_state = FAL_BURST;
            end
         end
         FAL_BURST: begin
            // only a reset leaves the burst
            nxt_state = FAL_BURST;
         end
         default: begin
            nxt_state = FAL_HOLD;
         end
      endcase
      // only this block pulls the pin, and rw_ff follows the state, so the pin is never low outside hold;
      // the term is kept so the bit4 restart does not hinge on that
      // pin reset or ready_wait low with bit4 restarts the sequence from hold
      if (hold_w | (~rw_ff & cfg_bit4_i & (state_ff != FAL_HOLD))) begin
         nxt_state = FAL_HOLD;
      end
   end

   // ------------------------------------------------------------
   // sequencer registers
   // ------------------------------------------------------------
   // pin level is a flop of its own, so the pin never glitches
   // while the state decode settles
   // state and ready_wait pin
   always_ff @(posedge ref_clk_i or posedge reset_i) begin
      if (reset_i) begin
         state_ff <= FAL_HOLD;
         rw_ff    <= 1'b0;
         rw_d_ff  <= 1'b0;
      end else begin
         state_ff <= nxt_state;
         rw_ff    <= (nxt_state != FAL_HOLD);
         rw_d_ff  <= rw_ff;
      end
   end

   // the counter stops at the release count, so it cannot wrap
   // and release the pin a second time
   // hold counter: counts only while held low
   always_ff @(posedge ref_clk_i or posedge reset_i) begin
      if (reset_i) begin
         low_cnt_ff <= 16'h0;
      end else if (nxt_state != FAL_HOLD || hold_w) begin
         low_cnt_ff <= 16'h0;                            // restart while pin reset
      end else if (!rel_w) begin
         low_cnt_ff <= low_cnt_ff + 16'h1;
      end
   end

   // oe_seen keeps a start armed when the enable fell with the pin high
   // but the other reader controls were not yet in place
   // power-on phase flags; pin reset does not reopen it
   always_ff @(posedge ref_clk_i or posedge reset_i) begin
      if (reset_i) begin
         por_ff     <= 1'b1;
         oe_seen_ff <= 1'b0;
         oe_n_d_ff  <= 1'b1;
      end else begin
         oe_n_d_ff <= ctl_i.oe_n;
         if (start_w) begin
            por_ff <= 1'b0;
         end
         if (oe_fall_w & rw_ff) begin
            oe_seen_ff <= 1'b1;
         end else if (ctl_i.oe_n) begin
            oe_seen_ff <= 1'b0;
         end
      end
   end

   // the count wraps on the fourth edge; harmless, since it is cleared
   // whenever the state is not the sequence state
   // edge counter; third edge in sequence latches address
   always_ff @(posedge ref_clk_i or posedge reset_i) begin
      if (reset_i) begin
         seq_cnt_ff <= SEQ_CNT_RST;
         addr_ff    <= ADDR_RST;
      end else begin
         if (state_ff != FAL_SEQ) begin
            seq_cnt_ff <= SEQ_CNT_RST;
         end else begin
            seq_cnt_ff <= seq_cnt_ff + 2'h1;
         end
         if (cap_w) begin
            addr_ff <= addr_i;
         end else if (state_ff == FAL_BURST) begin
            addr_ff <= addr_ff + {{(AW-1){1'b0}}, 1'b1};
         end
      end
   end

   // ------------------------------------------------------------
   // output data: one word every edge, no wait states
   // ------------------------------------------------------------
   // data follows the array every cycle; only the enable flag says
   // whether the word is meant for the reader
   // limitation: array must return the word in the same cycle
   always_ff @(posedge ref_clk_i or posedge reset_i) begin
      if (reset_i) begin
         dout_ff <= '0;
      end else begin
         dout_ff.oe   <= (state_ff == FAL_BURST) & ~ctl_i.oe_n;
         dout_ff.data <= array_data_i;
      end
   end

   // ------------------------------------------------------------
   // erase timing bound
   // ------------------------------------------------------------
   fal_erase_timer u_erase (
      .ref_clk_i (ref_clk_i),
      .reset_i   (reset_i),
      .start_i   (erase_start_i),
      .is_main_i (erase_main_i),
      .busy_o    (busy_w)
   );
   // extra flop keeps every top-level output except ready_wait_oe_o (inverted rw_ff) straight from a register
   logic busy_ff;                                        // registered busy
   always_ff @(posedge ref_clk_i or posedge reset_i) begin
      if (reset_i) begin
         busy_ff <= 1'b0;
      end else begin
         busy_ff <= busy_w;
      end
   end

   // ------------------------------------------------------------
   // outputs
   // ------------------------------------------------------------
   assign ready_wait_o    = rw_ff;
   assign ready_wait_oe_o = ~rw_ff;    // open drain: drive only the low level
   assign array_addr_o    = addr_ff;
   assign dout_o          = dout_ff;
   assign erase_busy_o    = busy_ff;
endmodule

// *** sim/fal_first_addr_chk.sv ***
`timescale 1ns/100ps
// ------------------------------------------------------------
// port checker
// ------------------------------------------------------------
module fal_first_addr_chk #(
   parameter int RW_LOW = 10,
   parameter int AW     = 23
) (
   input wire logic               ref_clk_i,
   input wire logic               reset_i,
   input wire fal_pkg::fal_ctl_t  ctl_i,
   input wire logic               cfg_bit4_i,
   input wire logic [15:0]        array_data_i,
   input wire logic               erase_start_i,
   input wire logic               ready_wait_o,
   input wire logic               ready_wait_oe_o,
   input wire logic [AW-1:0]      array_addr_o,
   input wire fal_pkg::fal_dout_t dout_o,
   input wire logic               erase_busy_o
);
   import fal_pkg::*;
   default clocking @(posedge ref_clk_i); endclocking
   default disable iff (reset_i);
   AST_PIN_DRIVE: assert property (ready_wait_oe_o == !ready_wait_o)
      else $error("pin enable does not mirror the pin");
   AST_PIN_RESET: assert property (!ctl_i.hard_reset_n |-> ##[0:2] !ready_wait_o)
      else $error("pin not held low under reset pin");
   AST_LOW_TIME: assert property ($rose(ready_wait_o) |-> !$past(ready_wait_o, RW_LOW))
      else $error("pin released too early");
   AST_SEQ_CLEAR: assert property (!ready_wait_o && cfg_bit4_i |-> ##3 !dout_o.oe)
      else $error("sequence not cleared while pin low");
   AST_OE_GATE: assert property (dout_o.oe |-> $past(!ctl_i.oe_n))
      else $error("data driven without output enable");
   AST_DATA_PATH: assert property (dout_o.oe |-> dout_o.data == $past(array_data_i))
      else $error("word is not the array word");
   AST_BURST_STEP: assert property (dout_o.oe && $past(dout_o.oe) && ready_wait_o
      && $past(ready_wait_o) |-> array_addr_o == AW'($past(array_addr_o) + 1))
      else $error("burst address did not step by one");
   AST_ERASE_BUSY: assert property (erase_start_i |-> ##[1:2] erase_busy_o)
      else $error("erase request not seen as busy");
endmodule

bind fal_first_addr fal_first_addr_chk #(.RW_LOW(RW_LOW), .AW(AW)) fal_first_addr_chk_inst (
   .ref_clk_i(ref_clk_i), .reset_i(reset_i), .ctl_i(ctl_i), .cfg_bit4_i(cfg_bit4_i),
   .array_data_i(array_data_i), .erase_start_i(erase_start_i), .ready_wait_o(ready_wait_o),
   .ready_wait_oe_o(ready_wait_oe_o), .array_addr_o(array_addr_o), .dout_o(dout_o),
   .erase_busy_o(erase_busy_o));

// *** sim/fal_reader.sv ***
`timescale 1ns/100ps
// ------------------------------------------------------------
// reader model on the far side
// ------------------------------------------------------------
module fal_reader (
   input  wire logic         ref_clk_i,
   input  wire logic         ready_wait_i, // pin level seen
   input  wire logic         oe_n_i,       // requested enable
   input  wire logic         hrst_n_i,     // requested reset pin
   input  wire logic [22:0]  addr_req_i,   // next start address
   output fal_pkg::fal_ctl_t ctl_o,        // controls toward device
   output logic [22:0]       addr_o        // address toward device
);
   import fal_pkg::*;
   // strobe always high; address moves only while the pin is low,
   // so it stays put through and well past the fourth edge
   always_ff @(posedge ref_clk_i) begin
      ctl_o <= '{oe_n: oe_n_i, addr_valid: 1'b1, hard_reset_n: hrst_n_i};
      if (!ready_wait_i) begin
         addr_o <= addr_req_i;
      end
   end
endmodule

// *** sim/fal_first_addr_bench.sv ***
`timescale 1ns/100ps
module fal_first_addr_bench;
   import fal_pkg::*;
   logic        ref_clk_i, reset_i, oe_n, hrst_n, cfg_bit4_i, erase_start_i, erase_main_i;
   logic [22:0] addr_req, addr_i, array_addr_o;
   logic [15:0] array_data_i;
   fal_ctl_t    ctl_i;
   fal_dout_t   dout_o;
   logic        ready_wait_o, ready_wait_oe_o, erase_busy_o;
   int          fails = 0;
   int          comparisons = 0;
   // array contents: a plain pattern of the address
   assign array_data_i = array_addr_o[15:0] ^ 16'h5a5a;
   fal_reader fal_reader_inst (.ref_clk_i(ref_clk_i), .ready_wait_i(ready_wait_o),
      .oe_n_i(oe_n), .hrst_n_i(hrst_n), .addr_req_i(addr_req), .ctl_o(ctl_i), .addr_o(addr_i));
   fal_first_addr #(.RW_LOW(RW_LOW_CYC)) fal_first_addr_inst (.ref_clk_i(ref_clk_i),
      .reset_i(reset_i), .ctl_i(ctl_i), .addr_i(addr_i), .cfg_bit4_i(cfg_bit4_i),
      .array_data_i(array_data_i), .erase_start_i(erase_start_i), .erase_main_i(erase_main_i),
      .ready_wait_o(ready_wait_o), .ready_wait_oe_o(ready_wait_oe_o),
      .array_addr_o(array_addr_o), .dout_o(dout_o), .erase_busy_o(erase_busy_o));
   task automatic check(input logic [31:0] seen, input logic [31:0] exp);
      comparisons++;
      if (seen !== exp) begin
         fails++;
         $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
      end
   endtask
   task automatic wrap_up();
      $display("comparisons=%0d fails=%0d", comparisons, fails);
      if (fails == 0 && comparisons > 0) begin
         $display("No errors found");
      end else begin
         $display("Errors were found");
      end
      $finish;
   endtask
   function automatic logic [15:0] word_at(input logic [22:0] a);
      return a[15:0] ^ 16'h5a5a;
   endfunction
   // bounded wait for the pin release
   task automatic wait_rw(output int n);
      n = 0;
      while (ready_wait_o !== 1'b1 && n < 40) begin
         @(negedge ref_clk_i);
         n++;
      end
   endtask
   // capture on the third edge, then burst from that address
   task automatic capture(input logic [22:0] a);
      int n;
      n = 0;
      while (array_addr_o !== a && n < 8) begin
         @(negedge ref_clk_i);
         n++;
      end
      check(n >= 3 && n <= 6, 1);
      n = 0;
      while (dout_o.oe !== 1'b1 && n < 8) begin
         @(negedge ref_clk_i);
         n++;
      end
      check(dout_o.oe, 1);
      check(dout_o.data, word_at(a));
      repeat (4) @(negedge ref_clk_i);
      check(dout_o.data, word_at(a + 23'h4));
   endtask
   task automatic por_case();
      int n;
      wait_rw(n);
      check(n >= RW_LOW_CYC, 1);
      // reader keeps its distance from the release before any enable edge
      repeat (6) @(negedge ref_clk_i);
      check(array_addr_o, 23'h0);
      @(posedge ref_clk_i);
      oe_n <= 1'b0;
      capture(23'h012345);
   endtask
   task automatic rst_case();
      int          n;
      logic [22:0] hold_a;
      @(posedge ref_clk_i);
      hrst_n <= 1'b0;
      addr_req <= 23'h7ffff0;
      repeat (5) @(negedge ref_clk_i);
      check(ready_wait_o, 0);
      check(ready_wait_oe_o, 1);
      check(dout_o.oe, 0);
      @(posedge ref_clk_i);
      hrst_n <= 1'b1;
      wait_rw(n);
      capture(23'h7ffff0);
      // second pin reset with the enable high: a late enable fall must not start
      @(posedge ref_clk_i);
      oe_n <= 1'b1;
      hrst_n <= 1'b0;
      addr_req <= 23'h055aa0;
      repeat (3) @(posedge ref_clk_i);
      hrst_n <= 1'b1;
      wait_rw(n);
      check(ready_wait_oe_o, 0);
      hold_a = array_addr_o;
      repeat (3) @(posedge ref_clk_i);
      oe_n <= 1'b0;
      repeat (8) begin
         @(negedge ref_clk_i);
         check(array_addr_o, hold_a);
         check(dout_o.oe, 0);
      end
   endtask
   // mid-run power-on reset with the enable already low: the release starts it
   task automatic por2_case();
      int n;
      @(posedge ref_clk_i);
      reset_i <= 1'b1;
      addr_req <= 23'h023456;
      repeat (3) @(posedge ref_clk_i);
      reset_i <= 1'b0;
      wait_rw(n);
      check(n >= RW_LOW_CYC, 1);
      capture(23'h023456);
   endtask
   task automatic erase_case();
      @(posedge ref_clk_i);
      erase_main_i <= 1'b1;
      erase_start_i <= 1'b1;
      @(posedge ref_clk_i);
      erase_start_i <= 1'b0;
      // busy shows two edges after the request: timer flop, then output flop
      @(posedge ref_clk_i);
      repeat (50) begin
         @(negedge ref_clk_i);
         check(erase_busy_o, 1);
      end
   endtask
   initial begin
      ref_clk_i = 1'b0;
      forever #50 ref_clk_i = ~ref_clk_i;
   end
   // hang guard: the whole run needs under two hundred cycles
   initial begin
      #(3000 * 100);
      fails++;
      wrap_up();
   end
   initial begin
      reset_i = 1'b1;
      oe_n = 1'b1;
      hrst_n = 1'b1;
      cfg_bit4_i = 1'b1;
      erase_start_i = 1'b0;
      erase_main_i = 1'b0;
      addr_req = 23'h012345;
      repeat (3) @(posedge ref_clk_i);
      check(ready_wait_o, 0);
      reset_i <= 1'b0;
      por_case();
      rst_case();
      por2_case();
      erase_case();
      wrap_up();
   end
endmodule
